// file: pde_map.svh
// Register offsets, field positions, reset values and timing counts of the port pair.
`ifndef PDE_MAP_SVH
`define PDE_MAP_SVH

// ****************************************
// Device register offsets
// ****************************************
`define PDE_OFF_PORT8_DATA 8'h08
`define PDE_OFF_PORT3_DATA 8'h09
`define PDE_OFF_PORT8_DIR 8'h88
`define PDE_OFF_PORT3_CTL 8'h89
`define PDE_OFF_ANALOG_CFG 8'h9F

// ****************************************
// Control register fields and reset values
// ****************************************
`define PDE_BIT_IN_PENDING 7
`define PDE_BIT_OUT_PENDING 6
`define PDE_BIT_IN_OVERRUN 5
`define PDE_BIT_SLAVE_EN 4
`define PDE_RST_PORT8_DIR 8'hFF
`define PDE_RST_PORT3_DIR 3'h7
`define PDE_RST_ANALOG 3'h7
`define PDE_RST_LATCH 8'h00

// ****************************************
// Pin positions on the small port
// ****************************************
`define PDE_PIN_RD 0
`define PDE_PIN_WR 1
`define PDE_PIN_CS 2

// ****************************************
// Controller register offsets and fields
// ****************************************
`define PDE_HOFF_CTRL 8'h00
`define PDE_HOFF_TXDATA 8'h04
`define PDE_HOFF_RXDATA 8'h08
`define PDE_HOFF_STATUS 8'h0C
`define PDE_HBIT_GO 0
`define PDE_HBIT_READ 1
`define PDE_HBIT_BUSY 0
`define PDE_HBIT_DONE 1

// ****************************************
// Timing
// ****************************************
`define PDE_CLK_NS 100
`define PDE_STROBE_NS 800
`define PDE_HOLD_NS 400
`define PDE_STROBE_CYC ((`PDE_STROBE_NS + `PDE_CLK_NS - 1) / `PDE_CLK_NS)
`define PDE_HOLD_CYC ((`PDE_HOLD_NS + `PDE_CLK_NS - 1) / `PDE_CLK_NS)

`endif

// file: pde_pkg.sv
// Types used by the bus controller end of the port pair only.
package pde_pkg;

  // Sequencer states of the external bus controller.
  typedef enum logic [1:0] {
    HS_IDLE,
    HS_SETUP,
    HS_STROBE,
    HS_HOLD
  } pde_host_state_t;

  // Counter wide enough for every timing count.
  typedef logic [3:0] pde_cnt_t;

endpackage

// file: pde_if.sv
// Pin-level carrier between the port device and the external bus controller.
`timescale 1ns/1ps

interface pde_if;

  // Drive and enable of each party on the 8-bit port.
  logic [7:0] dev_p8_out;
  logic [7:0] dev_p8_oe;
  logic [7:0] host_p8_out;
  logic [7:0] host_p8_oe;
  // Drive and enable of each party on the 3-pin port.
  logic [2:0] dev_p3_out;
  logic [2:0] dev_p3_oe;
  logic [2:0] host_p3_out;
  logic [2:0] host_p3_oe;
  // Resolved pin levels.
  logic [7:0] p8_level;
  logic [2:0] p3_level;

  // An undriven pin floats high through a pull-up; the device wins a clash.
  assign p8_level = (dev_p8_oe & dev_p8_out) | (~dev_p8_oe & host_p8_oe & host_p8_out) | (~dev_p8_oe & ~host_p8_oe);
  assign p3_level = (dev_p3_oe & dev_p3_out) | (~dev_p3_oe & host_p3_oe & host_p3_out) | (~dev_p3_oe & ~host_p3_oe);

  modport dev (
    output dev_p8_out,
    output dev_p8_oe,
    output dev_p3_out,
    output dev_p3_oe,
    input p8_level,
    input p3_level
  );

  modport host (
    output host_p8_out,
    output host_p8_oe,
    output host_p3_out,
    output host_p3_oe,
    input p8_level,
    input p3_level
  );

endinterface

// file: pde_host.sv
// External 8-bit bus controller, ordered by software over APB.
`timescale 1ns/1ps
`include "pde_map.svh"

module pde_host (
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic RST,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Pins.
  pde_if.host LINK
);

  pde_pkg::pde_host_state_t state_ff;
  pde_pkg::pde_cnt_t cnt_ff;
  logic ready_ff;
  logic err_ff;
  logic [31:0] prdata_ff;
  logic [7:0] tx_ff;
  logic [7:0] rx_ff;
  logic read_ff;
  logic done_ff;
  logic cs_n_ff;
  logic rd_n_ff;
  logic wr_n_ff;
  logic drive_ff;
  logic [7:0] p8_s1_ff;
  logic [7:0] p8_s2_ff;
  logic apb_wr;
  logic go;
  logic mapped;

  // ****************************************
  // APB slave
  // ****************************************

  // One wait state lets read data come from a flip-flop.
  assign PREADY = ready_ff;
  assign PRDATA = prdata_ff;
  assign PSLVERR = err_ff;
  assign apb_wr = PSEL && PENABLE && ready_ff && PWRITE;
  assign go = apb_wr && (PADDR == `PDE_HOFF_CTRL) && PWDATA[`PDE_HBIT_GO] && (state_ff == pde_pkg::HS_IDLE);
  assign mapped = (PADDR == `PDE_HOFF_CTRL) || (PADDR == `PDE_HOFF_TXDATA) ||
                  (PADDR == `PDE_HOFF_RXDATA) || (PADDR == `PDE_HOFF_STATUS);

  // Access phase answer and read data.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ready_ff <= 1'b0;
      err_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      ready_ff <= PSEL && PENABLE && !ready_ff;
      err_ff <= PSEL && PENABLE && !ready_ff && !mapped;
      prdata_ff <= 32'h0000_0000;
      if (PSEL && PENABLE && !ready_ff && !PWRITE) begin
        case (PADDR)
          `PDE_HOFF_CTRL: prdata_ff <= {30'h0000_0000, read_ff, 1'b0};
          `PDE_HOFF_TXDATA: prdata_ff <= {24'h00_0000, tx_ff};
          `PDE_HOFF_RXDATA: prdata_ff <= {24'h00_0000, rx_ff};
          `PDE_HOFF_STATUS: prdata_ff <= {30'h0000_0000, done_ff, state_ff != pde_pkg::HS_IDLE};
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software data and direction; a busy controller ignores a new order.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      tx_ff <= 8'h00;
      read_ff <= 1'b0;
    end else begin
      if (apb_wr && PADDR == `PDE_HOFF_TXDATA && state_ff == pde_pkg::HS_IDLE) begin
        tx_ff <= PWDATA[7:0];
      end
      if (go) begin
        read_ff <= PWDATA[`PDE_HBIT_READ];
      end
    end
  end

  // ****************************************
  // Bus sequencer
  // ****************************************

  // Pin levels are asynchronous to this controller, so they pass two flip-flops.
  always_ff @(posedge CLOCK) begin
    p8_s1_ff <= LINK.p8_level;
    p8_s2_ff <= p8_s1_ff;
  end

  // Select, strobe low for a fixed time, then hold select, and data on a write.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_ff <= pde_pkg::HS_IDLE;
      cnt_ff <= 4'h0;
      cs_n_ff <= 1'b1;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      drive_ff <= 1'b0;
      done_ff <= 1'b0;
      rx_ff <= 8'h00;
    end else begin
      case (state_ff)
        pde_pkg::HS_IDLE: begin
          if (go) begin
            state_ff <= pde_pkg::HS_SETUP;
            cs_n_ff <= 1'b0;
            drive_ff <= !PWDATA[`PDE_HBIT_READ];
            done_ff <= 1'b0;
          end
        end
        pde_pkg::HS_SETUP: begin
          state_ff <= pde_pkg::HS_STROBE;
          cnt_ff <= 4'(`PDE_STROBE_CYC - 1);
          rd_n_ff <= !read_ff;
          wr_n_ff <= read_ff;
        end
        pde_pkg::HS_STROBE: begin
          if (cnt_ff == 4'h0) begin
            state_ff <= pde_pkg::HS_HOLD;
            cnt_ff <= 4'(`PDE_HOLD_CYC - 1);
            rd_n_ff <= 1'b1;
            wr_n_ff <= 1'b1;
            if (read_ff) begin
              rx_ff <= p8_s2_ff;
            end
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        pde_pkg::HS_HOLD: begin
          if (cnt_ff == 4'h0) begin
            state_ff <= pde_pkg::HS_IDLE;
            cs_n_ff <= 1'b1;
            drive_ff <= 1'b0;
            done_ff <= 1'b1;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        default: state_ff <= pde_pkg::HS_IDLE;
      endcase
    end
  end

  // Pin drive; the controller always owns the three strobe pins.
  assign LINK.host_p3_out = {cs_n_ff, wr_n_ff, rd_n_ff};
  assign LINK.host_p3_oe = 3'h7;
  assign LINK.host_p8_out = tx_ff;
  assign LINK.host_p8_oe = {8{drive_ff}};

endmodule

// file: pde_dev.sv
// 8-bit port and 3-pin port with slave parallel port, processor register side and pin side.
//
// The implementer's own choice: the simple address, write-enable and read-enable register port.
`timescale 1ns/1ps
`include "pde_map.svh"

module pde_dev (
  // Clock and resets.
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic POR,
  // Processor register port.
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WE,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RE,
  output logic [7:0] REG_RDATA,
  // Pins.
  pde_if.dev LINK
);

  logic [7:0] port8_direction_ff;
  logic [7:0] port8_data_latch_ff;
  logic [7:0] in_buf_ff;
  logic [2:0] port3_dir_ff;
  logic [2:0] port3_data_ff;
  logic [2:0] analog_pin_config_ff;
  logic slave_port_enable_ff;
  logic in_word_pending_ff;
  logic out_word_pending_ff;
  logic in_word_overrun_ff;
  logic [7:0] rdata_ff;
  logic [7:0] p8_s1_ff;
  logic [7:0] p8_s2_ff;
  logic [2:0] p3_s1_ff;
  logic [2:0] p3_s2_ff;
  logic [2:0] p3_s3_ff;
  logic ext_rd_active;
  logic ext_rd_end;
  logic ext_wr_end;
  logic cpu_rd_port8;
  logic cpu_wr_port8;
  logic cpu_wr_ctl;
  logic [7:0] ctl_view;
  logic [2:0] port3_view;

  // Register address match, shared by the read and write decoders.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************

  // Strobes and data are asynchronous to this clock; a third stage gives edges.
  always_ff @(posedge CLOCK) begin
    p8_s1_ff <= LINK.p8_level;
    p8_s2_ff <= p8_s1_ff;
    p3_s1_ff <= LINK.p3_level;
    p3_s2_ff <= p3_s1_ff;
    p3_s3_ff <= p3_s2_ff;
  end

  // Read is active while select and read strobe are both low.
  assign ext_rd_active = slave_port_enable_ff && !p3_s2_ff[`PDE_PIN_RD] && !p3_s2_ff[`PDE_PIN_CS];
  // Transfers complete on the rising strobe edge, counted only if selected.
  assign ext_rd_end = slave_port_enable_ff && p3_s2_ff[`PDE_PIN_RD] && !p3_s3_ff[`PDE_PIN_RD] &&
                      !p3_s3_ff[`PDE_PIN_CS];
  assign ext_wr_end = slave_port_enable_ff && p3_s2_ff[`PDE_PIN_WR] && !p3_s3_ff[`PDE_PIN_WR] &&
                      !p3_s3_ff[`PDE_PIN_CS];

  // ****************************************
  // Processor register decode
  // ****************************************

  assign cpu_rd_port8 = REG_RE && hit(REG_ADDR, `PDE_OFF_PORT8_DATA);
  assign cpu_wr_port8 = REG_WE && hit(REG_ADDR, `PDE_OFF_PORT8_DATA);
  assign cpu_wr_ctl = REG_WE && hit(REG_ADDR, `PDE_OFF_PORT3_CTL);
  // Bit 3 is unimplemented and reads as zero.
  assign ctl_view = {in_word_pending_ff, out_word_pending_ff, in_word_overrun_ff, slave_port_enable_ff,
                     1'b0, port3_dir_ff};
  // Analog pins read as zero whatever their level.
  assign port3_view = p3_s2_ff & ~analog_pin_config_ff;

  // ****************************************
  // Configuration registers
  // ****************************************

  // Direction and control state reset on every reset.
  always_ff @(posedge CLOCK) begin
    if (RST || POR) begin
      port8_direction_ff <= `PDE_RST_PORT8_DIR;
      port3_dir_ff <= `PDE_RST_PORT3_DIR;
      slave_port_enable_ff <= 1'b0;
    end else begin
      if (REG_WE && hit(REG_ADDR, `PDE_OFF_PORT8_DIR)) begin
        port8_direction_ff <= REG_WDATA;
      end
      if (cpu_wr_ctl) begin
        port3_dir_ff <= REG_WDATA[2:0];
        slave_port_enable_ff <= REG_WDATA[`PDE_BIT_SLAVE_EN];
      end
    end
  end

  // Analog selection and data latches survive resets other than power-on.
  always_ff @(posedge CLOCK) begin
    if (POR) begin
      analog_pin_config_ff <= `PDE_RST_ANALOG;
      port8_data_latch_ff <= `PDE_RST_LATCH;
      port3_data_ff <= `PDE_RST_ANALOG;
      in_buf_ff <= `PDE_RST_LATCH;
    end else begin
      if (REG_WE && hit(REG_ADDR, `PDE_OFF_ANALOG_CFG)) begin
        analog_pin_config_ff <= REG_WDATA[2:0];
      end
      if (cpu_wr_port8) begin
        port8_data_latch_ff <= REG_WDATA;
      end
      if (REG_WE && hit(REG_ADDR, `PDE_OFF_PORT3_DATA)) begin
        port3_data_ff <= REG_WDATA[2:0];
      end
      if (ext_wr_end) begin
        in_buf_ff <= p8_s2_ff;
      end
    end
  end

  // ****************************************
  // Slave port status flags
  // ****************************************

  // A hardware set wins over a clear in the same cycle, so no event is lost.
  always_ff @(posedge CLOCK) begin
    if (RST || POR) begin
      in_word_pending_ff <= 1'b0;
      out_word_pending_ff <= 1'b0;
      in_word_overrun_ff <= 1'b0;
    end else begin
      if (ext_wr_end) begin
        in_word_pending_ff <= 1'b1;
      end else if (cpu_rd_port8 && slave_port_enable_ff) begin
        in_word_pending_ff <= 1'b0;
      end
      if (cpu_wr_port8 && slave_port_enable_ff) begin
        out_word_pending_ff <= 1'b1;
      end else if (ext_rd_end) begin
        out_word_pending_ff <= 1'b0;
      end
      if (ext_wr_end && in_word_pending_ff) begin
        in_word_overrun_ff <= 1'b1;
      end else if (cpu_wr_ctl) begin
        in_word_overrun_ff <= REG_WDATA[`PDE_BIT_IN_OVERRUN];
      end
    end
  end

  // ****************************************
  // Register read data
  // ****************************************

  // Read data appears one clock after the read request.
  always_ff @(posedge CLOCK) begin
    if (RST || POR) begin
      rdata_ff <= 8'h00;
    end else if (REG_RE) begin
      case (REG_ADDR)
        `PDE_OFF_PORT8_DATA: rdata_ff <= slave_port_enable_ff ? in_buf_ff : p8_s2_ff;
        `PDE_OFF_PORT3_DATA: rdata_ff <= {5'h00, port3_view};
        `PDE_OFF_PORT8_DIR: rdata_ff <= port8_direction_ff;
        `PDE_OFF_PORT3_CTL: rdata_ff <= ctl_view;
        `PDE_OFF_ANALOG_CFG: rdata_ff <= {5'h00, analog_pin_config_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  assign REG_RDATA = rdata_ff;

  // ****************************************
  // Pin drive
  // ****************************************

  // In slave mode the port drives only during a selected external read.
  assign LINK.dev_p8_out = port8_data_latch_ff;
  assign LINK.dev_p8_oe = slave_port_enable_ff ? {8{ext_rd_active}} : ~port8_direction_ff;
  // The small port keeps obeying its direction bits, even for analog pins; a
  // wrong setting in slave mode would fight the controller's strobes.
  assign LINK.dev_p3_out = port3_data_ff;
  assign LINK.dev_p3_oe = ~port3_dir_ff;

endmodule

// file: pde_link_assertions.sv
// Concurrent checks on the pin carrier between the port device and the bus controller.
`timescale 1ns/1ps

module pde_link_assertions (
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic RST,
  // Carrier signals.
  input wire logic [7:0] dev_p8_oe,
  input wire logic [2:0] dev_p3_oe,
  input wire logic [7:0] host_p8_oe,
  input wire logic [2:0] p3_level
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  // ****************************************
  // Strobe sequences
  // ****************************************
  // Read strobe and select seen low together for two samples, enough for both sync stages.
  sequence sel_read_s;
    (!p3_level[0] && !p3_level[2]) [*2];
  endsequence
  // Write strobe held low for the whole strobe time.
  sequence wr_low_s;
    (!p3_level[1]) [*8];
  endsequence
  // Select and data held after the write strobe returns, so the late capture sees settled data.
  sequence wr_hold_s;
    (!p3_level[2] && host_p8_oe == 8'hFF) [*3];
  endsequence

  // ****************************************
  // Checks
  // ****************************************
  // Reset releases every device pin driver and the controller's data drivers; the controller's strobe pins stay driven high.
  dev_reset_idle_a: assert property (disable iff (1'b0) RST |=> dev_p8_oe == 8'h00 && dev_p3_oe == 3'h0)
    else $error("device drives a pin after reset");
  host_reset_idle_a: assert property (disable iff (1'b0) RST |=> p3_level == 3'h7 && host_p8_oe == 8'h00)
    else $error("controller not idle after reset");
  // The device answers a selected read by driving the whole port.
  read_drive_a: assert property (sel_read_s |=> &dev_p8_oe)
    else $error("device does not drive the port on a selected read");
  read_release_a: assert property ($rose(p3_level[0]) |-> ##3 dev_p8_oe == 8'h00)
    else $error("device keeps driving after the read strobe ends");
  // Only one party may drive the data pins at a time.
  bus_clash_a: assert property (host_p8_oe != 8'h00 |-> dev_p8_oe == 8'h00)
    else $error("both parties drive the data pins");
  strobe_select_a: assert property ((!p3_level[0] || !p3_level[1]) |-> !p3_level[2])
    else $error("strobe active without select");
  strobe_excl_a: assert property (!(!p3_level[0] && !p3_level[1]))
    else $error("read and write strobes active together");
  write_pulse_a: assert property ($fell(p3_level[1]) |-> wr_low_s ##1 p3_level[1])
    else $error("write strobe width wrong");
  write_hold_a: assert property ($rose(p3_level[1]) |-> wr_hold_s)
    else $error("select or data dropped too early after write");
endmodule

// file: pde_tb.sv
// Testbench joining the port device and the bus controller, driven over both register ports.
`timescale 1ns/1ps
`include "pde_map.svh"

module tb;
  logic clock, rst, por, reg_we, reg_re, psel, penable, pwrite, pready, pslverr, errv;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, paddr, bytev;
  logic [31:0] pwdata, prdata, rdv;
  int miscompares;
  int n_tests;

  pde_if link();

  pde_dev u_pde_dev (.CLOCK(clock), .RST(rst), .POR(por), .REG_ADDR(reg_addr), .REG_WE(reg_we),
    .REG_WDATA(reg_wdata), .REG_RE(reg_re), .REG_RDATA(reg_rdata), .LINK(link));
  pde_host u_pde_host (.CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(link));
  pde_link_assertions u_chk (.CLOCK(clock), .RST(rst), .dev_p8_oe(link.dev_p8_oe), .dev_p3_oe(link.dev_p3_oe),
    .host_p8_oe(link.host_p8_oe), .p3_level(link.p3_level));

  // Free-running 10 MHz clock.
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Compares one result; four-state compare so an unknown never matches.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Processor register write; the task starts on a fresh edge so strobes never collide.
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clock);
    reg_we <= 1'b0;
  endtask

  // Processor register read checked against an expected byte.
  task automatic reg_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clock);
    reg_re <= 1'b0;
    @(negedge clock);
    bytev = reg_rdata;
    chk(what, {24'h0, exp}, {24'h0, bytev});
  endtask

  // One APB transfer; waits as long as the slave needs, only the watchdog ends a hang.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Orders one external bus transfer and polls for its completion.
  task automatic xfer(input logic rd, input logic [7:0] tx);
    int n;
    apb(1'b1, `PDE_HOFF_TXDATA, {24'h0, tx});
    apb(1'b1, `PDE_HOFF_CTRL, {30'h0, rd, 1'b1});
    n = 0;
    do begin
      apb(1'b0, `PDE_HOFF_STATUS, 32'h0);
      n++;
    end while (rdv[`PDE_HBIT_DONE] !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    if (rd) apb(1'b0, `PDE_HOFF_RXDATA, 32'h0);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole sequence needs a few hundred cycles.
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    stop_test();
  end

  // Main sequence.
  initial begin
    {rst, por} = 2'b11;
    {reg_we, reg_re, psel, penable, pwrite} = 5'h00;
    {reg_addr, reg_wdata, paddr} = 24'h0;
    pwdata = 32'h0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    por <= 1'b0;
    reg_chk("dir8", `PDE_OFF_PORT8_DIR, 8'hFF);
    reg_chk("ctl", `PDE_OFF_PORT3_CTL, 8'h07);
    reg_chk("analog", `PDE_OFF_ANALOG_CFG, 8'h07);
    reg_chk("port3", `PDE_OFF_PORT3_DATA, 8'h00);
    reg_wr(`PDE_OFF_PORT3_CTL, 8'hCF);
    reg_chk("ctl ro", `PDE_OFF_PORT3_CTL, 8'h07);
    // Plain I/O: low nibble driven, high nibble floats high.
    reg_wr(`PDE_OFF_PORT8_DATA, 8'hA5);
    reg_wr(`PDE_OFF_PORT8_DIR, 8'hF0);
    repeat (3) @(negedge clock);
    chk("p8 oe", 32'h0F, {24'h0, link.dev_p8_oe});
    chk("p8 pins", 32'hF5, {24'h0, link.p8_level});
    reg_chk("p8 read", `PDE_OFF_PORT8_DATA, 8'hF5);
    reg_wr(`PDE_OFF_PORT8_DIR, 8'hFF);
    // Small port as outputs, then one pin analog.
    reg_wr(`PDE_OFF_ANALOG_CFG, 8'h00);
    reg_wr(`PDE_OFF_PORT3_DATA, 8'h03);
    reg_wr(`PDE_OFF_PORT3_CTL, 8'h00);
    repeat (3) @(negedge clock);
    chk("p3 pins", 32'h3, {29'h0, link.p3_level});
    reg_chk("p3 read", `PDE_OFF_PORT3_DATA, 8'h03);
    reg_wr(`PDE_OFF_ANALOG_CFG, 8'h01);
    reg_chk("p3 analog", `PDE_OFF_PORT3_DATA, 8'h02);
    chk("p3 oe", 32'h7, {29'h0, link.dev_p3_oe});
    reg_wr(`PDE_OFF_PORT3_CTL, 8'h07);
    reg_wr(`PDE_OFF_ANALOG_CFG, 8'h00);
    // Slave port off: an external write must leave the flags alone.
    xfer(1'b0, 8'h3C);
    reg_chk("frozen", `PDE_OFF_PORT3_CTL, 8'h07);
    // Slave port on: writes, pending flag and overrun.
    reg_wr(`PDE_OFF_PORT3_CTL, 8'h17);
    xfer(1'b0, 8'h5A);
    reg_chk("in pend", `PDE_OFF_PORT3_CTL, 8'h97);
    reg_chk("in word", `PDE_OFF_PORT8_DATA, 8'h5A);
    reg_chk("in clear", `PDE_OFF_PORT3_CTL, 8'h17);
    xfer(1'b0, 8'hC3);
    xfer(1'b0, 8'h7E);
    reg_chk("overrun", `PDE_OFF_PORT3_CTL, 8'hB7);
    reg_chk("drain", `PDE_OFF_PORT8_DATA, 8'h7E);
    reg_chk("ovr stays", `PDE_OFF_PORT3_CTL, 8'h37);
    reg_wr(`PDE_OFF_PORT3_CTL, 8'h17);
    reg_chk("ovr clear", `PDE_OFF_PORT3_CTL, 8'h17);
    // Processor word read by the external master.
    reg_wr(`PDE_OFF_PORT8_DATA, 8'h69);
    reg_chk("out pend", `PDE_OFF_PORT3_CTL, 8'h57);
    xfer(1'b1, 8'h00);
    chk("ext read", 32'h69, rdv);
    reg_chk("out clear", `PDE_OFF_PORT3_CTL, 8'h17);
    // Warm reset keeps latch and analog setting; power-on restores analog.
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    reg_chk("ctl rst", `PDE_OFF_PORT3_CTL, 8'h07);
    reg_chk("dir rst", `PDE_OFF_PORT8_DIR, 8'hFF);
    reg_chk("analog kept", `PDE_OFF_ANALOG_CFG, 8'h00);
    reg_wr(`PDE_OFF_PORT8_DIR, 8'h00);
    // The driven level needs two synchroniser stages before a pin read can see it.
    repeat (2) @(posedge clock);
    reg_chk("latch kept", `PDE_OFF_PORT8_DATA, 8'h69);
    @(posedge clock);
    por <= 1'b1;
    repeat (2) @(posedge clock);
    por <= 1'b0;
    reg_chk("analog por", `PDE_OFF_ANALOG_CFG, 8'h07);
    apb(1'b0, 8'h10, 32'h0);
    chk("apb unmapped", 32'h1, {31'h0, errv});
    stop_test();
  end
endmodule
